// *** src/hpb_pkg.sv ***
// Package for the host parallel bus port: constants, timing and states.
// Assumes a single 100 MHz clock domain and host pins synchronous to it.
// Behaviour
// RULE1 - Single reads reach registers and FIFOs
// RULE2 - Counter values latched at read start
// RULE3 - Read runs while select and read low
// RULE4 - Host keeps strobes high between cycles
// RULE5 - Host stretches cycles to minimum length
// RULE6 - Up to sixteen words per burst
// RULE7 - Host keeps strobes high between bursts
// RULE8 - FIFO select reads receive data FIFO
// RULE9 - Direct mode keeps low address bits
// RULE10 - FIFO select timed like address lines
// RULE11 - Direct FIFO bursts have no length limit
// RULE12 - Host honours deassertion gap in bursts
// RULE13 - Every write is a single cycle
// RULE14 - Write runs while select and write low
// RULE15 - FIFO select writes transmit data FIFO
// RULE16 - Host splits long bursts into sixteen (the bench sends one 17-word plain burst unsplit)
// RULE17 - Host waits after side-effect reads
package hpb_pkg;
  localparam int          ADDR_W       = 7;
  localparam int          DATA_W       = 16;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          T_CSH_NS     = 13;
  localparam int          T_CYCLE_NS   = 165;
  // Least times round up
  localparam int          CSH_CYC      =
    (T_CSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CYCLE_CYC    =
    (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          BURST_MAX    = 16;
  // Address index bits 2:1 sit at index 1:0 (A[0] absent on 16-bit bus)
  localparam int          LOW_ADDR_MSB = 1;
  localparam int          LOW_ADDR_LSB = 0;
  localparam logic [15:0] RD_DATA_RST  = 16'h0000;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } hpb_state_type;
endpackage

// *** src/hpb_skid.sv ***
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; upstream holds data while in_ready is low.
`timescale 1ns/1ps
module hpb_skid (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Fill side
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [15:0] in_data,
  // Drain side
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [15:0]      out_data
);
  logic [15:0] mem_reg [2];
  logic        wr_ptr_reg;
  logic        rd_ptr_reg;
  logic [1:0]  cnt_reg;
  logic        push;
  logic        pop;

  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg    <= 2'h0;
    end else begin
      if (push)
        wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk) begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data;
  end

  // Head word held in a register: a pop from a full buffer exposes the
  // other stored entry; a push that becomes the head shows the new word,
  // also when the only stored word leaves at the same edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      out_data <= 16'h0000;
    else if (pop && cnt_reg == 2'h2)
      out_data <= mem_reg[~rd_ptr_reg];
    else if (push && (cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop)))
      out_data <= in_data;
  end

  a_skid_no_over: assert property (@(posedge clk) disable iff (!reset_n)
    cnt_reg <= 2'h2) else $error("buffer count overflow");
endmodule

// *** src/hpb_port.sv ***
// Host parallel bus port: decodes chip select and strobes into reads
// and writes, routes direct FIFO traffic and buffers written words.
// Assumes host pins synchronous to REF_CLK and the core answers reads
// combinationally from its latched counters and FIFO heads.
`timescale 1ns/1ps
module hpb_port (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  // Host bus
  input  wire logic        CHIP_SELECT_LOW,
  input  wire logic        READ_STROBE_LOW,
  input  wire logic        WRITE_STROBE_LOW,
  input  wire logic        FIFO_SEL,
  input  wire logic [6:0]  ADDR,
  input  wire logic [15:0] DATA_IN,
  output logic [15:0]      DATA_OUT,
  output logic             DATA_OE,
  // Core read side
  output logic             CNT_LATCH,
  output logic             CSR_RD,
  output logic             RXD_RD,
  output logic [6:0]       RD_ADDR,
  input  wire logic [15:0] CSR_RDATA,
  input  wire logic [15:0] RXD_RDATA,
  // Core write side
  output logic             WR_VALID,
  input  wire logic        WR_READY,
  output logic [15:0]      WR_DATA,
  output logic [6:0]       WR_ADDR,
  output logic             WR_TXD,
  output logic             WR_STALL
);
  hpb_pkg::hpb_state_type state_reg;
  logic        rd_act;
  logic        wr_act;
  logic        rd_start;
  logic        wr_end;
  logic        addr_chg;
  logic [6:0]  addr_prev_reg;
  logic [15:0] wdata_reg;
  logic [6:0]  waddr_reg;
  logic        wfifo_reg;
  logic [4:0]  burst_cnt_reg;
  logic [6:0]  eff_addr;
  logic        in_ready;
  logic [15:0] buf_data;
  logic        buf_valid;
  logic [7:0]  side_head;

  assign rd_act = !CHIP_SELECT_LOW && !READ_STROBE_LOW; // RULE3
  assign wr_act = !CHIP_SELECT_LOW && !WRITE_STROBE_LOW; // RULE14
  assign rd_start = rd_act && (state_reg != hpb_pkg::ST_READ);
  assign wr_end   = !wr_act && (state_reg == hpb_pkg::ST_WRITE);
  assign addr_chg = rd_act && (state_reg == hpb_pkg::ST_READ)
                    && (ADDR != addr_prev_reg);
  // Direct mode keeps only the low word-select bits
  assign eff_addr = FIFO_SEL ?
    {5'h00, ADDR[hpb_pkg::LOW_ADDR_MSB:hpb_pkg::LOW_ADDR_LSB]} // RULE9
    : ADDR;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N)
      state_reg <= hpb_pkg::ST_IDLE;
    else if (rd_act)
      state_reg <= hpb_pkg::ST_READ;
    else if (wr_act)
      state_reg <= hpb_pkg::ST_WRITE;
    else
      state_reg <= hpb_pkg::ST_IDLE;
  end

  // Burst word counter; beyond the limit plain bursts return stale data
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      burst_cnt_reg <= 5'h00;
      addr_prev_reg <= 7'h00;
    end else begin
      addr_prev_reg <= ADDR;
      if (rd_start)
        burst_cnt_reg <= 5'h01;
      else if (addr_chg && burst_cnt_reg != 5'(hpb_pkg::BURST_MAX))
        burst_cnt_reg <= burst_cnt_reg + 5'h01; // RULE6
    end
  end

  // Each new word strobe pulls one item from the addressed source; plain bursts stop pulling after BURST_MAX words
  always_comb begin
    CNT_LATCH = rd_start; // RULE2
    RD_ADDR   = eff_addr;
    RXD_RD    = (rd_start || addr_chg) && FIFO_SEL; // RULE8 RULE11
    CSR_RD    = (rd_start || (addr_chg && burst_cnt_reg
                 != 5'(hpb_pkg::BURST_MAX))) && !FIFO_SEL; // RULE1 RULE6
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DATA_OUT <= hpb_pkg::RD_DATA_RST;
      DATA_OE  <= 1'b0;
    end else begin
      // Enable trails the strobes by one clock; the host allows for it
      DATA_OE <= rd_act; // RULE3
      if (RXD_RD)
        DATA_OUT <= RXD_RDATA;
      else if (CSR_RD)
        DATA_OUT <= CSR_RDATA;
    end
  end

  // Capture address and data while strobed; commit at the ending edge
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wdata_reg <= 16'h0000;
      waddr_reg <= 7'h00;
      wfifo_reg <= 1'b0;
    end else if (wr_act) begin
      wdata_reg <= DATA_IN; // RULE14
      waddr_reg <= eff_addr;
      wfifo_reg <= FIFO_SEL; // RULE15
    end
  end

  // Every write is one word: no burst write path exists
  // A word ending while the buffer is full is lost: the host must watch
  // the stall flag before it starts the next write
  hpb_skid i_hpb_skid (
    .clk       (REF_CLK),
    .reset_n   (RESET_N),
    .in_valid  (wr_end), // RULE13
    .in_ready  (in_ready),
    .in_data   (wdata_reg),
    .out_valid (buf_valid),
    .out_ready (WR_READY),
    .out_data  (buf_data)
  );

  // Side info for the word: the address travels with the data
  logic [7:0] side_q_reg [2];
  logic       side_w_reg;
  logic       side_r_reg;
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      side_w_reg    <= 1'b0;
      side_r_reg    <= 1'b0;
      side_q_reg[0] <= 8'h00;
      side_q_reg[1] <= 8'h00;
    end else begin
      if (wr_end && in_ready) begin
        side_q_reg[side_w_reg] <= {wfifo_reg, waddr_reg};
        side_w_reg             <= ~side_w_reg;
      end
      if (buf_valid && WR_READY)
        side_r_reg <= ~side_r_reg;
    end
  end

  assign side_head = side_q_reg[side_r_reg];
  assign WR_VALID  = buf_valid;
  assign WR_DATA   = buf_data;
  assign WR_ADDR   = side_head[6:0];
  assign WR_TXD    = side_head[7]; // RULE15
  // Host sees a stall when the buffer cannot take another word
  assign WR_STALL = !in_ready;

  // Read side: latching, routing and the data word
  a_read_latch: assert property ( // RULE2
    @(posedge REF_CLK) disable iff (!RESET_N)
    $rose(rd_act) |-> CNT_LATCH && (CSR_RD || RXD_RD))
    else $error("no latch at read");
  a_latch_once: assert property ( // RULE2
    @(posedge REF_CLK) disable iff (!RESET_N)
    CNT_LATCH |=> !CNT_LATCH)
    else $error("double latch in one read");
  a_read_oe: assert property ( // RULE3
    @(posedge REF_CLK) disable iff (!RESET_N)
    rd_act |=> DATA_OE)
    else $error("data not driven");
  a_read_end: assert property ( // RULE3
    @(posedge REF_CLK) disable iff (!RESET_N)
    !rd_act |=> !DATA_OE)
    else $error("data still driven");
  a_data_hold: assert property ( // RULE3
    @(posedge REF_CLK) disable iff (!RESET_N)
    !CSR_RD && !RXD_RD |=> $stable(DATA_OUT))
    else $error("read data moved without a read");
  a_csr_data: assert property ( // RULE1
    @(posedge REF_CLK) disable iff (!RESET_N)
    CSR_RD |=> DATA_OUT == $past(CSR_RDATA))
    else $error("register word not returned");
  a_rx_data: assert property ( // RULE8
    @(posedge REF_CLK) disable iff (!RESET_N)
    RXD_RD |=> DATA_OUT == $past(RXD_RDATA))
    else $error("fifo word not returned");
  a_fifo_route: assert property ( // RULE8
    @(posedge REF_CLK) disable iff (!RESET_N)
    FIFO_SEL |-> !CSR_RD)
    else $error("csr read in fifo mode");
  a_low_addr: assert property ( // RULE9
    @(posedge REF_CLK) disable iff (!RESET_N)
    FIFO_SEL |-> RD_ADDR[6:2] == 5'h00)
    else $error("high address bits used");
  a_burst_lim: assert property ( // RULE6
    @(posedge REF_CLK) disable iff (!RESET_N)
    burst_cnt_reg <= 5'(hpb_pkg::BURST_MAX))
    else $error("burst count too high");
  a_rx_unlim: assert property ( // RULE11
    @(posedge REF_CLK) disable iff (!RESET_N)
    addr_chg && FIFO_SEL |-> RXD_RD)
    else $error("fifo burst lost");

  // Write side: one buffered word per host write that finds the buffer not full
  a_write_once: assert property ( // RULE13
    @(posedge REF_CLK) disable iff (!RESET_N)
    wr_end && in_ready |=> buf_valid)
    else $error("write lost");
  a_stall_full: assert property ( // RULE13
    @(posedge REF_CLK) disable iff (!RESET_N)
    WR_STALL |-> WR_VALID)
    else $error("stall with empty buffer");
  a_write_data: assert property ( // RULE14
    @(posedge REF_CLK) disable iff (!RESET_N)
    $fell(wr_act) && in_ready && !buf_valid |=> WR_DATA == $past(wdata_reg))
    else $error("write data wrong");
  a_tx_route: assert property ( // RULE15
    @(posedge REF_CLK) disable iff (!RESET_N)
    wr_act && FIFO_SEL |=> wfifo_reg)
    else $error("tx route");
  a_tx_addr: assert property ( // RULE9
    @(posedge REF_CLK) disable iff (!RESET_N)
    wr_act && FIFO_SEL |=> waddr_reg[6:2] == 5'h00)
    else $error("tx address high bits kept");

  c_read: cover property (@(posedge REF_CLK) rd_start && !FIFO_SEL);
  c_burst: cover property (@(posedge REF_CLK) addr_chg && !FIFO_SEL);
  c_rx_fifo: cover property (@(posedge REF_CLK) RXD_RD);
  c_write: cover property (@(posedge REF_CLK) wr_end && wfifo_reg);
  c_stall: cover property (@(posedge REF_CLK) WR_STALL);
endmodule

// *** test/hpb_host.sv ***
// Host model: drives select, strobes, address and FIFO select.
// Assumes the port samples every pin on rising edges of clk.
`timescale 1ns/1ps
module hpb_host (
  // Clock
  input  wire logic        clk,
  // Host bus
  output logic             cs_low,
  output logic             rd_low,
  output logic             wr_low,
  output logic             fifo_sel,
  output logic [6:0]       addr,
  output logic [15:0]      wdata,
  // Read data from the port
  input  wire logic [15:0] rdata
);
  logic [15:0] bq[$];
  initial begin
    cs_low = 1'b1;
    rd_low = 1'b1;
    wr_low = 1'b1;
    fifo_sel = 1'b0;
    addr = 7'h00;
    wdata = 16'h0000;
  end
  // Idle so each cycle spans at least 17 clocks
  task automatic gap();
    repeat (9) @(posedge clk);
  endtask
  task automatic rd(input logic f, input logic [6:0] a, input logic rf,
                    output logic [15:0] d);
    fifo_sel <= f;
    addr <= a;
    if (rf) rd_low <= 1'b0;
    else cs_low <= 1'b0;
    @(posedge clk);
    rd_low <= 1'b0;
    cs_low <= 1'b0;
    repeat (7) @(posedge clk);
    d = rdata;
    cs_low <= 1'b1;
    rd_low <= 1'b1;
    addr <= ~a;
    gap();
  endtask
  // One word per 17 clocks, address moves each word
  task automatic burst(input logic f, input logic [6:0] a, input int n);
    bq.delete();
    fifo_sel <= f;
    cs_low <= 1'b0;
    rd_low <= 1'b0;
    for (int i = 0; i < n; i++) begin
      addr <= a + 7'(i);
      repeat (17) @(posedge clk);
      bq.push_back(rdata);
    end
    cs_low <= 1'b1;
    rd_low <= 1'b1;
    gap();
  endtask
  task automatic wr(input logic f, input logic [6:0] a, input logic [15:0] d);
    fifo_sel <= f;
    addr <= a;
    wdata <= d;
    cs_low <= 1'b0;
    wr_low <= 1'b0;
    repeat (8) @(posedge clk);
    cs_low <= 1'b1;
    wr_low <= 1'b1;
    // Released data lines show no stale word
    wdata <= ~d;
    gap();
  endtask
endmodule

// *** test/hpb_port_tb.sv ***
// Bench for the host port: host model on the bus, core model here.
// Assumes a 100 MHz REF_CLK and the port's two-entry write buffer.
`timescale 1ns/1ps
module hpb_port_tb;
  logic ref_clk, reset_n, cs_low, rd_low, wr_low, fsel, cnt_latch;
  logic csr_rd, rxd_rd, wr_valid, wr_ready, wr_txd, wr_stall, data_oe;
  logic [6:0] addr, rd_addr, wr_addr;
  logic [15:0] din, dout, wr_data, csr_rdata, rxd_rdata, d;
  logic [23:0] wq[$];
  int bad_count, total_checks, lat_n, rx_n, csr_n, oe_n;
  assign csr_rdata = {9'h000, rd_addr} ^ 16'hC3A0;
  // FIFO word carries the kept address bits so dropped masking shows
  assign rxd_rdata = 16'h5A00 + 16'(rx_n) + {rd_addr, 9'h000};
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (cnt_latch === 1'b1) lat_n <= lat_n + 1;
    if (csr_rd === 1'b1) csr_n <= csr_n + 1;
    if (rxd_rd === 1'b1) rx_n <= rx_n + 1;
    if (data_oe === 1'b1) oe_n <= oe_n + 1;
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      wq.push_back({wr_txd, wr_addr, wr_data});
  end
  hpb_host i_hpb_host (.clk(ref_clk), .cs_low(cs_low), .rd_low(rd_low),
    .wr_low(wr_low), .fifo_sel(fsel), .addr(addr), .wdata(din),
    .rdata(dout));
  hpb_port i_hpb_port (.REF_CLK(ref_clk), .RESET_N(reset_n),
    .CHIP_SELECT_LOW(cs_low), .READ_STROBE_LOW(rd_low),
    .WRITE_STROBE_LOW(wr_low), .FIFO_SEL(fsel), .ADDR(addr),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(data_oe),
    .CNT_LATCH(cnt_latch), .CSR_RD(csr_rd), .RXD_RD(rxd_rd),
    .RD_ADDR(rd_addr), .CSR_RDATA(csr_rdata), .RXD_RDATA(rxd_rdata),
    .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_DATA(wr_data),
    .WR_ADDR(wr_addr), .WR_TXD(wr_txd), .WR_STALL(wr_stall));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_single();
    logic [6:0] a[3] = '{7'h00, 7'h15, 7'h7F};
    for (int i = 0; i < 3; i++) begin
      i_hpb_host.rd(1'b0, a[i], a[i][0], d);
      chk(d, {9'h000, a[i]} ^ 16'hC3A0);
      chk(16'(lat_n), 16'(i + 1));
      chk(16'(oe_n), 16'(7 * (i + 1)));
    end
  endtask
  task automatic t_burst();
    i_hpb_host.burst(1'b0, 7'h10, 17);
    for (int i = 0; i < 16; i++)
      chk(i_hpb_host.bq[i], {9'h000, 7'h10 + 7'(i)} ^ 16'hC3A0);
    chk(i_hpb_host.bq[16], {9'h000, 7'h1F} ^ 16'hC3A0);
    chk(16'(lat_n), 16'h0004);
    chk(16'(csr_n), 16'h0013);
  endtask
  task automatic t_direct();
    i_hpb_host.rd(1'b1, 7'h7D, 1'b1, d);
    chk(d, 16'h5C00);
    i_hpb_host.burst(1'b1, 7'h3A, 20);
    for (int i = 0; i < 20; i++) begin
      d = 16'h5A01 + 16'(i) + {5'h00, 2'(7'h3A + 7'(i)), 9'h000};
      chk(i_hpb_host.bq[i], d);
    end
    chk(16'(rx_n), 16'h0015);
    chk(16'(csr_n), 16'h0013);
  endtask
  task automatic t_write();
    i_hpb_host.wr(1'b0, 7'h2B, 16'hBEEF);
    i_hpb_host.wr(1'b1, 7'h7E, 16'h1234);
    chk(wq[0][15:0], 16'hBEEF);
    chk({8'h00, wq[0][23:16]}, 16'h002B);
    chk({8'h00, wq[1][23:16]}, 16'h0082);
    chk(wq[1][15:0], 16'h1234);
    wq.delete();
    wr_ready <= 1'b0;
    i_hpb_host.wr(1'b0, 7'h01, 16'hA000);
    chk({15'h0000, wr_stall}, 16'h0000);
    i_hpb_host.wr(1'b0, 7'h02, 16'hA001);
    chk({15'h0000, wr_stall}, 16'h0001);
    // Written while stalled: the port drops this word
    i_hpb_host.wr(1'b0, 7'h03, 16'hA002);
    wr_ready <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk(16'(wq.size()), 16'h0002);
    foreach (wq[i]) chk(wq[i][15:0], 16'hA000 + 16'(i));
    chk({8'h00, wq[1][23:16]}, 16'h0002);
  endtask
  initial begin
    reset_n = 1'b0;
    wr_ready = 1'b1;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    t_single();
    t_burst();
    t_direct();
    t_write();
    end_sim();
  end
  initial begin
    #100000;
    bad_count++;
    end_sim();
  end
endmodule
